/* File: droop_wake_and_enable_sequencer.sv */
// Droop wake pulse and secondary enable sequencer top
// How it works
// - Power cycle counts only after wake line low at least 500 ns.
// - Reference sample taken at demag end, only for qualified low time.
// - Unqualified wake line disturbances leave the reference untouched.
// - Each qualified cycle loads reference as 97% of sampled supply.
// - Supply at or below reference starts pulling the wake line low.
// - Wake pulses last 1 us and repeat every 30 us.
// - Reference only guaranteed for cycle intervals up to 40 ms.
// - 32 cumulative periods under 57 us release the enable output.
// - 63 consecutive periods over 177 us pull the enable output low.
// - Both intervals come from one timebase, keeping their ratio fixed.
// - Enable output state and reference value held through lockout; all else disabled until lockout ends, active until lockout returns.
// - Wake line senses power cycles whenever out of lockout and not driving its own wake pulse.
// - Wake pulses repeat until a qualified cycle or lockout.
// - Enable output is high impedance after power-up.
// - A period under 177 us clears the consecutive disable count.
// - While enable output is low, long periods keep the enable count.
`include "droop_wake_map.svh"
module droop_wake_and_enable_sequencer (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire logic undervoltage_lockout_in,
    input wire logic wake_low_in,
    input wire logic [`SUPPLY_W-1:0] supply_level_in,
    output logic wake_pull_oe_out,
    output logic wake_pull_out,
    output logic secondary_enable_oe_out,
    output logic secondary_enable_out,
    output logic [`SUPPLY_W-1:0] droop_reference_out,
    output logic reference_valid_out
);
    import droop_wake_pkg::*;
    localparam int PW = `WAKE_PULSE_CYCLES;
    localparam int RP = `WAKE_REPEAT_CYCLES;
    localparam int EQ = `ENABLE_QUALIFY_CYCLES;
    localparam int DQ = `DISABLE_QUALIFY_CYCLES;
    localparam int MH = `MAX_HOLD_CYCLES;

    // Scale a supply sample to the droop threshold
    function automatic logic [`SUPPLY_W-1:0] scale_ref(input logic [`SUPPLY_W-1:0] v);
        logic [`SUPPLY_W+7:0] p;
        p = {8'h00, v} * (`SUPPLY_W+8)'(`REF_SCALE_NUM);
        return `SUPPLY_W'(p / (`SUPPLY_W+8)'(`REF_SCALE_DEN));
    endfunction : scale_ref

    // Reset release and pin synchronisers
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] undervoltage_lockout_sync_q, wake_sync_q;
    logic active, wake_low, qual;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            undervoltage_lockout_sync_q <= 2'b11;
            wake_sync_q <= 2'b00;
        end else begin
            undervoltage_lockout_sync_q <= {undervoltage_lockout_sync_q[0], undervoltage_lockout_in};
            wake_sync_q <= {wake_sync_q[0], wake_low_in};
        end
    end
    assign active = !undervoltage_lockout_sync_q[1];
    // Own pulses are masked so they are not seen as power cycles
    assign wake_low = wake_sync_q[1] && !wake_pull_out;

    low_time_qualifier u_qual (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .enable_in(active),
        .line_low_in(wake_low),
        .qualified_out(qual)
    );

    // Reference hold, period timer and counters
    logic [`SUPPLY_W-1:0] ref_q, ref_d;
    logic valid_q, valid_d;
    logic [`TIMER_W-1:0] per_q, per_d;
    logic [`CNT_W-1:0] en_cnt_q, en_cnt_d, dis_cnt_q, dis_cnt_d;
    logic ens_low_q, ens_low_d;
    logic first_q, first_d;
    always_comb begin
        ref_d = ref_q;
        valid_d = valid_q;
        per_d = per_q;
        en_cnt_d = en_cnt_q;
        dis_cnt_d = dis_cnt_q;
        ens_low_d = ens_low_q;
        first_d = first_q;
        if (!active) begin
            valid_d = 1'b0;
            per_d = '0;
            en_cnt_d = '0;
            dis_cnt_d = '0;
            first_d = 1'b1;
        end else if (qual) begin
            ref_d = scale_ref(supply_level_in);
            valid_d = 1'b1;
            per_d = '0;
            first_d = 1'b0;
            if (!first_q) begin
                if (per_q < `TIMER_W'(EQ)) begin
                    if (en_cnt_q == `CNT_W'(`ENABLE_CYCLE_COUNT - 1)) begin
                        ens_low_d = 1'b0;
                        en_cnt_d = '0;
                    end else begin
                        en_cnt_d = en_cnt_q + `CNT_W'(1);
                    end
                end else if (!ens_low_q) begin
                    en_cnt_d = '0;
                end
                if (per_q > `TIMER_W'(DQ)) begin
                    if (dis_cnt_q == `CNT_W'(`DISABLE_CYCLE_COUNT - 1)) begin
                        ens_low_d = 1'b1;
                        dis_cnt_d = '0;
                    end else begin
                        dis_cnt_d = dis_cnt_q + `CNT_W'(1);
                    end
                end else begin
                    dis_cnt_d = '0;
                end
            end
        end else begin
            if (per_q != {`TIMER_W{1'b1}}) begin
                per_d = per_q + `TIMER_W'(1);
            end
            if (per_q >= `TIMER_W'(MH)) begin
                valid_d = 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            ref_q <= '0;
            valid_q <= 1'b0;
            per_q <= '0;
            en_cnt_q <= '0;
            dis_cnt_q <= '0;
            ens_low_q <= 1'b0;
            first_q <= 1'b1;
        end else begin
            ref_q <= ref_d;
            valid_q <= valid_d;
            per_q <= per_d;
            en_cnt_q <= en_cnt_d;
            dis_cnt_q <= dis_cnt_d;
            ens_low_q <= ens_low_d;
            first_q <= first_d;
        end
    end

    // Wake pulse generator
    wake_state_t st_q, st_d;
    logic [15:0] wt_q, wt_d;
    logic droop;
    assign droop = active && (supply_level_in <= ref_q) && (ref_q != '0);
    always_comb begin
        st_d = st_q;
        wt_d = wt_q + 16'h0001;
        unique case (st_q)
            WK_IDLE: begin
                wt_d = '0;
                if (droop && !qual) begin
                    st_d = WK_PULSE;
                end
            end
            WK_PULSE: begin
                if (wt_q == 16'(PW - 1)) begin
                    st_d = WK_GAP;
                end
            end
            WK_GAP: begin
                if (qual) begin
                    st_d = WK_IDLE;
                end else if (wt_q == 16'(RP - 1)) begin
                    st_d = WK_PULSE;
                    wt_d = '0;
                end
            end
            default: begin
                st_d = WK_IDLE;
            end
        endcase
        if (!active) begin
            st_d = WK_IDLE;
            wt_d = '0;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= WK_IDLE;
            wt_q <= '0;
        end else begin
            st_q <= st_d;
            wt_q <= wt_d;
        end
    end

    assign wake_pull_out = (st_q == WK_PULSE);
    assign wake_pull_oe_out = (st_q == WK_PULSE);
    assign secondary_enable_out = 1'b0;
    assign secondary_enable_oe_out = ens_low_q;
    assign droop_reference_out = ref_q;
    assign reference_valid_out = valid_q;

    pulse_width_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        $rose(wake_pull_out) |-> wake_pull_out [*8])
        else $error("wake pulse too short");
    pulse_end_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        $rose(wake_pull_out) |-> ##[199:201] !wake_pull_out)
        else $error("wake pulse width wrong");
    lockout_quiet_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        !active |=> !wake_pull_out && en_cnt_q == '0 && dis_cnt_q == '0)
        else $error("activity during lockout");
    ref_update_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        active && qual |=> ref_q == scale_ref($past(supply_level_in)))
        else $error("reference not refreshed");
    ref_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        !qual |=> $stable(ref_q))
        else $error("reference changed without cycle");
    short_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        active && qual && !first_q && per_q <= `TIMER_W'(DQ) |=> dis_cnt_q == '0)
        else $error("disable count not cleared");
    ens_low_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        active && qual && ens_low_q && per_q >= `TIMER_W'(EQ) |=> en_cnt_q == $past(en_cnt_q))
        else $error("enable count lost while low");
    ens_release_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        $fell(ens_low_q) |-> $past(en_cnt_q) == `CNT_W'(31))
        else $error("enable released early");
    ens_pull_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        $rose(ens_low_q) |-> $past(dis_cnt_q) == `CNT_W'(62))
        else $error("enable pulled early");
    wake_seen_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n) $rose(wake_pull_out));
    repeat_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        st_q == WK_GAP && st_d == WK_PULSE);
    ens_low_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n) $rose(ens_low_q));
    ens_back_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n) $fell(ens_low_q));
endmodule : droop_wake_and_enable_sequencer

/* File: droop_wake_and_enable_sequencer_test.sv */
// Self-checking bench for the droop wake and enable sequencer
`include "droop_wake_map.svh"
module droop_wake_and_enable_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int len; logic [`SUPPLY_W-1:0] sup; bit qual;} row_t;
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic lockout = 1'b1;
    logic [`SUPPLY_W-1:0] supply = 12'h000;
    logic start = 1'b0;
    logic [15:0] low_len = 16'h0000;
    logic answer = 1'b0;
    logic line_low, pull_oe, pull, en_oe, en_out, ref_valid;
    logic [`SUPPLY_W-1:0] droop_ref;
    logic [`SUPPLY_W-1:0] exp_ref = 12'h000;
    wire logic sensed_low = line_low | pull;
    int err_total = 0;
    int comparisons = 0;
    int n;
    // Low lengths around the qualifying time, supply never below the held reference
    row_t rows [5] = '{'{120, 12'h400, 1'b1}, '{60, 12'h500, 1'b0}, '{90, 12'h600, 1'b0},
                       '{110, 12'h700, 1'b1}, '{300, 12'hfff, 1'b1}};

    droop_wake_and_enable_sequencer droop_wake_and_enable_sequencer_i (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .undervoltage_lockout_in(lockout),
        .wake_low_in(sensed_low),
        .supply_level_in(supply),
        .wake_pull_oe_out(pull_oe),
        .wake_pull_out(pull),
        .secondary_enable_oe_out(en_oe),
        .secondary_enable_out(en_out),
        .droop_reference_out(droop_ref),
        .reference_valid_out(ref_valid)
    );

    flyback_primary_model flyback_primary_model_i (
        .clk_in(clk_sys_in),
        .start_in(start),
        .low_len_in(low_len),
        .answer_wake_in(answer),
        .wake_pull_in(pull),
        .line_low_out(line_low)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    // Verdict and end of run
    task automatic final_report();
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    // Advance k edges, then step just past the edge
    task automatic cycles(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask : cycles

    // Bounded wait for a wake switch level, counting cycles
    task automatic wait_pull(input logic val, input int bound, output int cnt);
        cnt = 0;
        while (pull !== val) begin
            if (cnt == bound) begin
                err_total++;
                $display("ERROR wake_pull_wait expected %0h seen %0h", val, pull);
                final_report();
            end
            cycles(1);
            cnt++;
        end
    endtask : wait_pull

    // Count cycles that the wake switch stays open, up to k
    task automatic quiet(input int k, output int cnt);
        cnt = 0;
        while (pull === 1'b0 && cnt < k) begin
            cycles(1);
            cnt++;
        end
    endtask : quiet

    function automatic logic [`SUPPLY_W-1:0] ref_of(input logic [`SUPPLY_W-1:0] s);
        return `SUPPLY_W'((32'(s) * `REF_SCALE_NUM) / `REF_SCALE_DEN);
    endfunction : ref_of

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys_in);
        #1;
        resetn_in = 1'b1;
        lockout = 1'b0;
        cycles(6);
        check("reference_after_reset", 0, droop_ref);
        check("enable_oe_after_reset", 0, en_oe);
        check("wake_after_reset", 0, pull);
        // Power cycles with qualifying and disturbing low times
        foreach (rows[i]) begin
            supply = rows[i].sup;
            low_len = 16'(rows[i].len);
            start = 1'b1;
            cycles(1);
            start = 1'b0;
            cycles(rows[i].len + 50);
            if (rows[i].qual) begin
                exp_ref = ref_of(rows[i].sup);
            end
            check("droop_reference", exp_ref, droop_ref);
        end
        check("enable_oe_short_periods", 0, en_oe);
        check("enable_data", 0, en_out);
        check("reference_valid", 1, ref_valid);
        // Supply reaches the held reference exactly: pulses repeat unanswered
        supply = exp_ref;
        wait_pull(1'b1, 20, n);
        check("wake_oe", 1, pull_oe);
        wait_pull(1'b0, 400, n);
        check("wake_width", `WAKE_PULSE_CYCLES, n);
        wait_pull(1'b1, 7000, n);
        check("wake_repeat", `WAKE_REPEAT_CYCLES, n + `WAKE_PULSE_CYCLES);
        // Controller answers this pulse: repeats stop, reference refreshed
        answer = 1'b1;
        wait_pull(1'b0, 400, n);
        quiet(6500, n);
        check("wake_quiet_after_answer", 6500, n);
        check("reference_after_answer", ref_of(exp_ref), droop_ref);
        answer = 1'b0;
        // Deep droop, then lockout in the middle of a pulse
        supply = 12'h800;
        wait_pull(1'b1, 20, n);
        cycles(20);
        lockout = 1'b1;
        cycles(5);
        check("wake_in_lockout", 0, pull);
        check("wake_oe_in_lockout", 0, pull_oe);
        quiet(6500, n);
        check("wake_quiet_in_lockout", 6500, n);
        final_report();
    end
endmodule : droop_wake_and_enable_sequencer_test

/* File: droop_wake_map.svh */
// Timing counts and sizes for the droop wake and enable sequencer
`ifndef DROOP_WAKE_MAP_SVH
`define DROOP_WAKE_MAP_SVH
`define CLK_PERIOD_PS 5000
`define QUALIFY_LOW_TIME_NS 500
`define QUALIFY_LOW_CYCLES ((`QUALIFY_LOW_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WAKE_PULSE_TIME_NS 1000
`define WAKE_PULSE_CYCLES ((`WAKE_PULSE_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define WAKE_REPEAT_TIME_NS 30000
`define WAKE_REPEAT_CYCLES ((`WAKE_REPEAT_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define ENABLE_QUALIFY_TIME_NS 57000
`define ENABLE_QUALIFY_CYCLES ((`ENABLE_QUALIFY_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define DISABLE_QUALIFY_TIME_NS 177000
`define DISABLE_QUALIFY_CYCLES ((`DISABLE_QUALIFY_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define MAX_HOLD_INTERVAL_MS 40
// Hold limit worked in ns so the product stays inside 32-bit arithmetic
`define MAX_HOLD_CYCLES ((`MAX_HOLD_INTERVAL_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
`define ENABLE_CYCLE_COUNT 32
`define DISABLE_CYCLE_COUNT 63
`define REF_SCALE_NUM 97
`define REF_SCALE_DEN 100
`define SUPPLY_W 12
`define TIMER_W 24
`define CNT_W 6
`endif

/* File: droop_wake_pkg.sv */
// Types for the droop wake and enable sequencer
package droop_wake_pkg;
    typedef enum logic [2:0] {
        WK_IDLE = 3'b001,
        WK_PULSE = 3'b010,
        WK_GAP = 3'b100
    } wake_state_t;
endpackage : droop_wake_pkg

/* File: flyback_primary_model.sv */
// Primary-side controller model driving power-cycle lows on the wake line
module flyback_primary_model (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [15:0] low_len_in,
    input wire logic answer_wake_in,
    input wire logic wake_pull_in,
    output logic line_low_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] low_cnt = 16'h0000;
    logic [7:0] delay_cnt = 8'h00;
    logic pull_prev = 1'b0;
    // Winding holds the line low while the count runs
    assign line_low_out = (low_cnt != 16'h0000);
    // Low time started on demand, or some cycles after a wake pulse ends while answer_wake_in is set
    always @(posedge clk_in) begin
        pull_prev <= wake_pull_in;
        if (answer_wake_in && pull_prev && !wake_pull_in) begin
            delay_cnt <= 8'h40; // Slow reaction of the controller
        end else if (delay_cnt != 8'h00) begin
            delay_cnt <= delay_cnt - 8'h01;
        end
        if (start_in) begin
            low_cnt <= low_len_in;
        end else if (delay_cnt == 8'h01) begin
            low_cnt <= 16'h0078; // Answer long enough to qualify
        end else if (low_cnt != 16'h0000) begin
            low_cnt <= low_cnt - 16'h0001;
        end
    end
endmodule : flyback_primary_model

/* File: low_time_qualifier.sv */
// Wake line low-time qualifier, one pulse per qualified power cycle
`include "droop_wake_map.svh"
module low_time_qualifier (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic line_low_in,
    output logic qualified_out
);
    import droop_wake_pkg::*;
    localparam int QC = `QUALIFY_LOW_CYCLES;
    logic [7:0] low_cnt_q, low_cnt_d;
    logic armed_q, armed_d;
    logic pulse_q, pulse_d;

    // Count low time, fire at the rising edge that ends demag
    always_comb begin
        low_cnt_d = low_cnt_q;
        armed_d = armed_q;
        pulse_d = 1'b0;
        if (!enable_in) begin
            low_cnt_d = 8'h00;
            armed_d = 1'b0;
        end else if (line_low_in) begin
            if (low_cnt_q != 8'hff) begin
                low_cnt_d = low_cnt_q + 8'h01;
            end
            if (low_cnt_q >= 8'(QC - 1)) begin
                armed_d = 1'b1;
            end
        end else begin
            pulse_d = armed_q;
            armed_d = 1'b0;
            low_cnt_d = 8'h00;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            low_cnt_q <= 8'h00;
            armed_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            low_cnt_q <= low_cnt_d;
            armed_q <= armed_d;
            pulse_q <= pulse_d;
        end
    end

    assign qualified_out = pulse_q;

    short_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!line_low_in && low_cnt_q < 8'(QC) && !armed_q) |=> !qualified_out)
        else $error("short low time qualified");
    end_low_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        qualified_out |-> $past(line_low_in, 2) && !$past(line_low_in))
        else $error("qualify pulse not at low end");
endmodule : low_time_qualifier
